// file: logic/lpc_ctrl.v
// lpddr3 controller core: option checks, bring-up, refresh and write pacing
// Operation
// - exactly one chip select is driven toward the memory.
// - one differential memory clock is driven per chip select.
// - one clock enable is driven per chip select.
// - the data bus is built sixteen or thirty-two bits wide to match the device organisation.
// - the memory clock frequency option is legal only from 100 MHz to 400 MHz.
// - a build option includes write leveling or skips it during bring-up.
// - static options are fixed at elaboration and cannot change at run time.
// - only memory soldered on the board is supported.
// - bring-up writes a fixed burst length of eight into mode register one.
// - without the external refresh port the controller issues refresh bursts on its own.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_map.vh"
module lpc_ctrl #(
    parameter             CS_W       = `LPC_CS_W_DEF,
    parameter             DQ_W       = `LPC_DQ_W_DEF,
    parameter             FREQ_MHZ   = `LPC_FREQ_DEF_MHZ,
    parameter             MEM_TYPE   = `LPC_ONBOARD,
    parameter             WR_LVL_EN  = 1,
    parameter             WR_DELAY   = `LPC_WR_DLY_DEF,
    parameter             EXT_REF_EN = 0,
    parameter             REF_BURST  = `LPC_REF_BURST_DEF,
    parameter [31:0]      T_REF_INT  = `LPC_T_REFI_AB * `LPC_REF_BURST_DEF,
    parameter [15:0]      T_CKE      = `LPC_T_CKE,
    parameter [15:0]      T_MRW      = `LPC_T_MRW,
    parameter [15:0]      T_RCD      = `LPC_T_RCD,
    parameter [15:0]      T_RP       = `LPC_T_RP_AB,
    parameter [15:0]      T_RAS      = `LPC_T_RAS,
    parameter [15:0]      T_RFC      = `LPC_T_RFC_AB,
    parameter [15:0]      T_WLMRD    = `LPC_T_WLMRD
) (
    input  wire            i_clk_sys,
    input  wire            i_rstn,
    input  wire            i_ref_clk,
    input  wire            i_ext_ref_req,
    input  wire            i_wr_req,
    input  wire [DQ_W-1:0] i_wr_data,
    output reg  [CS_W-1:0] o_cs_n,
    output reg  [CS_W-1:0] o_ck_p,
    output reg  [CS_W-1:0] o_ck_n,
    output reg  [CS_W-1:0] o_cke,
    output reg  [3:0]      o_cmd,
    output reg  [7:0]      o_mr_addr,
    output reg  [7:0]      o_mr_data,
    output reg  [DQ_W-1:0] o_dq,
    output reg             o_dq_valid,
    output reg             o_wr_data_rdy,
    output reg             o_init_done,
    output reg             o_busy,
    output reg             o_cfg_err
);
    // ------------------------------------------------------------------------
    // option checks
    // ------------------------------------------------------------------------
    // options are parameters only, so nothing here can be changed by a running system
    localparam CFG_OK = (CS_W == `LPC_CS_W_MAX)
                      && (DQ_W == `LPC_DQ_W_X16 || DQ_W == `LPC_DQ_W_X32)
                      && (FREQ_MHZ >= `LPC_FREQ_MIN_MHZ)
                      && (FREQ_MHZ <= `LPC_FREQ_MAX_MHZ)
                      && (MEM_TYPE == `LPC_ONBOARD)
                      && (WR_DELAY >= `LPC_WR_DLY_MIN && WR_DELAY <= `LPC_WR_DLY_MAX);

    localparam [8:0] S_CKE  = 9'h001;
    localparam [8:0] S_MRW  = 9'h002;
    localparam [8:0] S_WLON = 9'h004;
    localparam [8:0] S_WLOF = 9'h008;
    localparam [8:0] S_IDLE = 9'h010;
    localparam [8:0] S_REF  = 9'h020;
    localparam [8:0] S_ACT  = 9'h040;
    localparam [8:0] S_WDAT = 9'h080;
    localparam [8:0] S_PRE  = 9'h100;

    // ------------------------------------------------------------------------
    // reference clock sampling and memory clock outputs
    // ------------------------------------------------------------------------
    reg ref_s1;
    reg ref_s2;

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
        end else begin
            ref_s1 <= i_ref_clk;
            ref_s2 <= ref_s1;
        end
    end

    reg [8:0]  state;
    reg        cke_on;
    reg        tload;
    reg [15:0] tval;
    wire       tdone;
    wire       twait_ok = tdone && !tload;
    wire       cke_start = (state == S_CKE) && CFG_OK && twait_ok;   // device must see cke high with the first mode write

    genvar g;
    generate
        for (g = 0; g < CS_W; g = g + 1) begin : g_cs
            always @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_ck_p[g] <= 1'b0;
                    o_ck_n[g] <= 1'b1;
                    o_cke[g]  <= 1'b0;
                end else begin
                    o_ck_p[g] <= ref_s2;
                    o_ck_n[g] <= ~ref_s2;
                    o_cke[g]  <= cke_on || cke_start;
                end
            end
        end
    endgenerate

    lpc_timer #(
        .W       (`LPC_T_W)
    ) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_load    (tload),
        .i_value   (tval),
        .o_done    (tdone)
    );

    // ------------------------------------------------------------------------
    // refresh scheduling
    // ------------------------------------------------------------------------
    reg [31:0] ref_cnt;
    reg [15:0] ref_left;
    reg        ext_pend;
    wire       ref_due = (EXT_REF_EN != 0) ? ext_pend : (ref_cnt >= T_REF_INT);

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_cnt  <= 32'h0000_0000;
            ext_pend <= 1'b0;
        end else begin
            if (state == S_REF) begin
                ref_cnt <= 32'h0000_0000;
            end else if (o_init_done && ref_cnt != 32'hffff_ffff) begin
                ref_cnt <= ref_cnt + 32'h0000_0001;
            end
            // a new request in the cycle the burst starts stays pending
            if (i_ext_ref_req) begin
                ext_pend <= 1'b1;
            end else if (state == S_IDLE && ref_due) begin
                ext_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------------
    reg [1:0] wr_cnt;

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state         <= S_CKE;
            cke_on        <= 1'b0;
            tload         <= 1'b1;
            tval          <= T_CKE;
            ref_left      <= 16'h0000;
            wr_cnt        <= 2'h0;
            o_cs_n        <= {CS_W{1'b1}};
            o_cmd         <= `LPC_CMD_NOP;
            o_mr_addr     <= 8'h00;
            o_mr_data     <= 8'h00;
            o_dq          <= {DQ_W{1'b0}};
            o_dq_valid    <= 1'b0;
            o_wr_data_rdy <= 1'b0;
            o_init_done   <= 1'b0;
            o_busy        <= 1'b1;
            o_cfg_err     <= 1'b0;
        end else begin
            tload         <= 1'b0;
            o_cs_n        <= {CS_W{1'b1}};
            o_cmd         <= `LPC_CMD_NOP;
            o_dq_valid    <= 1'b0;
            o_wr_data_rdy <= 1'b0;
            o_cfg_err     <= !CFG_OK;
            o_busy        <= (state != S_IDLE);
            case (state)
                S_CKE: begin
                    // an illegal build never leaves reset power-down
                    if (CFG_OK && twait_ok) begin
                        cke_on <= 1'b1;
                        o_cs_n <= {CS_W{1'b0}};
                        o_cmd  <= `LPC_CMD_MRW;
                        o_mr_addr <= `LPC_MR_ADDR_1;
                        o_mr_data <= `LPC_MR1_BL8;
                        tload  <= 1'b1;
                        tval   <= T_MRW;
                        state  <= S_MRW;
                    end
                end
                S_MRW: begin
                    if (twait_ok) begin
                        if (WR_LVL_EN != 0) begin
                            o_cs_n    <= {CS_W{1'b0}};
                            o_cmd     <= `LPC_CMD_MRW;
                            o_mr_addr <= `LPC_MR_ADDR_2;
                            o_mr_data <= `LPC_MR2_WL_ON;
                            tload     <= 1'b1;
                            tval      <= T_WLMRD;
                            state     <= S_WLON;
                        end else begin
                            o_init_done <= 1'b1;
                            state       <= S_IDLE;
                        end
                    end
                end
                S_WLON: begin
                    if (twait_ok) begin
                        o_cs_n    <= {CS_W{1'b0}};
                        o_cmd     <= `LPC_CMD_MRW;
                        o_mr_addr <= `LPC_MR_ADDR_2;
                        o_mr_data <= `LPC_MR2_WL_OFF;
                        tload     <= 1'b1;
                        tval      <= T_MRW;
                        state     <= S_WLOF;
                    end
                end
                S_WLOF: begin
                    if (twait_ok) begin
                        o_init_done <= 1'b1;
                        state       <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    // refresh takes priority over a waiting write
                    if (ref_due) begin
                        ref_left <= REF_BURST[15:0];
                        state    <= S_REF;
                    end else if (i_wr_req) begin
                        o_cs_n <= {CS_W{1'b0}};
                        o_cmd  <= `LPC_CMD_ACT;
                        tload  <= 1'b1;
                        tval   <= T_RCD;
                        state  <= S_ACT;
                    end
                end
                S_REF: begin
                    if (twait_ok) begin
                        if (ref_left == 16'h0000) begin
                            state <= S_IDLE;
                        end else begin
                            o_cs_n   <= {CS_W{1'b0}};
                            o_cmd    <= `LPC_CMD_REF;
                            ref_left <= ref_left - 16'h0001;
                            tload    <= 1'b1;
                            tval     <= T_RFC;
                        end
                    end
                end
                S_ACT: begin
                    if (twait_ok) begin
                        o_wr_data_rdy <= 1'b1;
                        wr_cnt        <= 2'h0;
                        tload         <= 1'b1;
                        tval          <= T_RAS;
                        state         <= S_WDAT;
                    end
                end
                S_WDAT: begin
                    // data is sampled exactly WR_DELAY cycles after the ready pulse
                    if (wr_cnt == WR_DELAY[1:0] - 2'h1) begin
                        o_dq       <= i_wr_data;
                        o_dq_valid <= 1'b1;
                        o_cs_n     <= {CS_W{1'b0}};
                        o_cmd      <= `LPC_CMD_WR;
                        wr_cnt     <= 2'h3;
                    end else if (wr_cnt != 2'h3) begin
                        wr_cnt <= wr_cnt + 2'h1;
                    end else if (twait_ok) begin
                        o_cs_n <= {CS_W{1'b0}};
                        o_cmd  <= `LPC_CMD_PRE;
                        tload  <= 1'b1;
                        tval   <= T_RP;
                        state  <= S_PRE;
                    end
                end
                S_PRE: begin
                    if (twait_ok) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_CKE;
                end
            endcase
        end
    end
endmodule // lpc_ctrl
`default_nettype wire

// file: include/lpc_map.vh
// constants for the lpddr3 controller configuration layer
`ifndef LPC_MAP_VH
`define LPC_MAP_VH

// ----------------------------------------------------------------------------
// build-time option defaults and legal bounds
// ----------------------------------------------------------------------------
`define LPC_CS_W_DEF       1
`define LPC_CS_W_MAX       1
`define LPC_DQ_W_DEF       32
`define LPC_DQ_W_X16       16
`define LPC_DQ_W_X32       32
`define LPC_FREQ_DEF_MHZ   400
`define LPC_FREQ_MIN_MHZ   100
`define LPC_FREQ_MAX_MHZ   400
`define LPC_WR_DLY_DEF     1
`define LPC_WR_DLY_MIN     1
`define LPC_WR_DLY_MAX     2
`define LPC_REF_BURST_DEF  32
`define LPC_ONBOARD        1

// ----------------------------------------------------------------------------
// timing defaults in system clock cycles
// ----------------------------------------------------------------------------
`define LPC_T_W            16
`define LPC_T_CKE          16'h0004
`define LPC_T_MRW          16'h000a
`define LPC_T_RCD          16'h0008
`define LPC_T_RP_AB        16'h0009
`define LPC_T_RAS          16'h0011
`define LPC_T_RFC_AB       16'h0034
`define LPC_T_REFI_AB      16'h0618
`define LPC_T_WLMRD        16'h0028

// ----------------------------------------------------------------------------
// command codes and mode register fields
// ----------------------------------------------------------------------------
`define LPC_CMD_NOP        4'h0
`define LPC_CMD_MRW        4'h1
`define LPC_CMD_REF        4'h2
`define LPC_CMD_ACT        4'h3
`define LPC_CMD_WR         4'h4
`define LPC_CMD_PRE        4'h5
`define LPC_MR_ADDR_1      8'h01
`define LPC_MR_ADDR_2      8'h02
`define LPC_MR1_BL8        8'h03
`define LPC_MR2_WL_ON      8'h80
`define LPC_MR2_WL_OFF     8'h00

`endif

// file: logic/lpc_timer.v
// down counter that paces waits between memory commands
`timescale 1ns/1ps
`default_nettype none
module lpc_timer #(
    parameter W = 16
) (
    input  wire         i_clk_sys,
    input  wire         i_rstn,
    input  wire         i_load,
    input  wire [W-1:0] i_value,
    output wire         o_done
);
    reg [W-1:0] cnt;

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= {W{1'b0}};
        end else if (i_load) begin
            cnt <= i_value;
        end else if (cnt != {W{1'b0}}) begin
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign o_done = (cnt == {W{1'b0}});
endmodule // lpc_timer
`default_nettype wire

// file: verification/lpc_ctrl_monitor.sv
// port-level checker for the lpddr3 controller core
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_monitor #(
    parameter int DQ_W     = 32,
    parameter int CS_W     = 1,
    parameter int WR_DELAY = 1,
    parameter int MIN_GAP  = 4
) (
    input wire logic            i_clk_sys,
    input wire logic            i_rstn,
    input wire logic            i_ref_clk,
    input wire logic [DQ_W-1:0] i_wr_data,
    input wire logic [CS_W-1:0] o_cs_n,
    input wire logic [CS_W-1:0] o_ck_p,
    input wire logic [CS_W-1:0] o_ck_n,
    input wire logic [CS_W-1:0] o_cke,
    input wire logic [3:0]      o_cmd,
    input wire logic [7:0]      o_mr_addr,
    input wire logic [7:0]      o_mr_data,
    input wire logic [DQ_W-1:0] o_dq,
    input wire logic            o_dq_valid,
    input wire logic            o_wr_data_rdy,
    input wire logic            o_init_done
);
    logic [7:0] gap;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // cycles since the last command; saturates so a long idle never wraps
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) gap <= 8'hff;
        else if (o_cmd != 4'h0) gap <= 8'h01;
        else if (gap != 8'hff) gap <= gap + 8'h01;
    end
    a_cs_with_cmd: assert property ((o_cs_n == '0) == (o_cmd != 4'h0))
        else $error("chip select and command disagree");
    a_ck_pair_inv: assert property (o_ck_n == ~o_ck_p)
        else $error("memory clock pair not inverse");
    a_ck_tracks_ref: assert property ($rose(i_ref_clk) |-> ##3 $rose(o_ck_p[0]))
        else $error("memory clock lags reference wrongly");
    a_cke_on_mr1: assert property ($rose(o_cke[0]) |-> o_cmd == 4'h1 && o_mr_addr == 8'h01 && o_mr_data == 8'h03)
        else $error("clock enable rose without burst length write");
    a_cke_holds: assert property (o_cke[0] |=> o_cke[0])
        else $error("clock enable dropped");
    a_rdy_to_data: assert property (o_wr_data_rdy |-> ##WR_DELAY (o_dq_valid && o_cmd == 4'h4 && o_dq == $past(i_wr_data)))
        else $error("write data not taken at set delay");
    a_dq_holds: assert property (!o_dq_valid |-> $stable(o_dq))
        else $error("write data moved without write");
    a_cmd_spacing: assert property (o_cmd != 4'h0 |-> gap >= MIN_GAP)
        else $error("commands too close");
    a_init_mrw_only: assert property (!o_init_done && o_cmd != 4'h0 |-> o_cmd == 4'h1)
        else $error("non mode write during bring-up");
endmodule // lpc_ctrl_monitor
bind lpc_ctrl lpc_ctrl_monitor #(.DQ_W(DQ_W), .CS_W(CS_W), .WR_DELAY(WR_DELAY)) u_mon (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ref_clk(i_ref_clk), .i_wr_data(i_wr_data),
    .o_cs_n(o_cs_n), .o_ck_p(o_ck_p), .o_ck_n(o_ck_n), .o_cke(o_cke), .o_cmd(o_cmd),
    .o_mr_addr(o_mr_addr), .o_mr_data(o_mr_data), .o_dq(o_dq), .o_dq_valid(o_dq_valid),
    .o_wr_data_rdy(o_wr_data_rdy), .o_init_done(o_init_done));
`default_nettype wire

// file: verification/lpc_mem_model.sv
// memory device model: records mode writes, refreshes and write data
`timescale 1ns/1ps
`default_nettype none
module lpc_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_cs_n,
    input  wire logic        i_cke,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [7:0]  i_mr_addr,
    input  wire logic [7:0]  i_mr_data,
    input  wire logic [31:0] i_dq,
    output logic      [7:0]  o_mr1,
    output logic             o_wl_seen,
    output logic      [15:0] o_ref_cnt,
    output logic      [31:0] o_last_wr
);
    // commands count only while clock enable is high, as a real device would
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mr1 <= 8'h00;
            o_wl_seen <= 1'b0;
            o_ref_cnt <= 16'h0000;
            o_last_wr <= 32'h0;
        end else if (i_cke && !i_cs_n) begin
            if (i_cmd == 4'h1 && i_mr_addr == 8'h01) o_mr1 <= i_mr_data;
            if (i_cmd == 4'h1 && i_mr_addr == 8'h02 && i_mr_data == 8'h80) o_wl_seen <= 1'b1;
            if (i_cmd == 4'h2) o_ref_cnt <= o_ref_cnt + 16'h0001;
            if (i_cmd == 4'h4) o_last_wr <= i_dq;
        end
    end
endmodule // lpc_mem_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the lpddr3 controller core
`timescale 1ns/1ps
`default_nettype none
`include "lpc_map.vh"
module tb_top;
    localparam int WRD = 1;
    logic        i_clk_sys = 1'b0;
    logic        i_rstn    = 1'b0;
    logic        i_ref_clk = 1'b0;
    logic        ext_req   = 1'b0;
    logic        wr_req    = 1'b0;
    logic [31:0] wr_data   = 32'h0;
    logic [31:0] seed      = 32'h0000_6301;
    logic [31:0] d;
    int          errors = 0;
    int          samples_checked = 0;
    wire logic [0:0]  cs_n, ck_p, ck_n, cke, x_cke;
    wire logic [3:0]  cmd;
    wire logic [7:0]  mr_addr, mr_data, mr1;
    wire logic [31:0] dq, last_wr;
    wire logic [15:0] ref_cnt;
    wire logic        dq_valid, rdy, init_done, busy, cfg_err, x_err, wl_seen;
    wire logic [3:0]  x_cmd;
    wire logic        x_cs_n, x_done, x_busy, x_dqv, x_rdy;
    always #50 i_clk_sys = ~i_clk_sys;
    initial begin
        #137;
        forever #400 i_ref_clk = ~i_ref_clk;
    end
    // command timings stay at their defaults so the spacing checks see the real counts; only the refresh interval is cut to 200 and the refresh burst to 2
    lpc_ctrl #(.WR_DELAY(WRD), .REF_BURST(2), .T_REF_INT(32'd200)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ref_clk(i_ref_clk), .i_ext_ref_req(ext_req),
        .i_wr_req(wr_req), .i_wr_data(wr_data), .o_cs_n(cs_n), .o_ck_p(ck_p), .o_ck_n(ck_n), .o_cke(cke),
        .o_cmd(cmd), .o_mr_addr(mr_addr), .o_mr_data(mr_data), .o_dq(dq), .o_dq_valid(dq_valid),
        .o_wr_data_rdy(rdy), .o_init_done(init_done), .o_busy(busy), .o_cfg_err(cfg_err));
    // illegal frequency and delay: must refuse bring-up
    lpc_ctrl #(.FREQ_MHZ(450), .WR_DELAY(3)) dut_x (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ref_clk(i_ref_clk), .i_ext_ref_req(ext_req),
        .i_wr_req(wr_req), .i_wr_data(wr_data), .o_cs_n(x_cs_n), .o_ck_p(), .o_ck_n(), .o_cke(x_cke),
        .o_cmd(x_cmd), .o_mr_addr(), .o_mr_data(), .o_dq(), .o_dq_valid(x_dqv), .o_wr_data_rdy(x_rdy),
        .o_init_done(x_done), .o_busy(x_busy), .o_cfg_err(x_err));
    lpc_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cs_n(cs_n[0]), .i_cke(cke[0]),
        .i_cmd(cmd), .i_mr_addr(mr_addr), .i_mr_data(mr_data), .i_dq(dq), .o_mr1(mr1),
        .o_wl_seen(wl_seen), .o_ref_cnt(ref_cnt), .o_last_wr(last_wr));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic cond(input int w);
        case (w)
            0: return init_done === 1'b1;
            1: return cmd === 4'h3;
            2: return rdy === 1'b1;
            default: return busy === 1'b0;
        endcase
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_for(input int w);
        int n;
        n = 0;
        while (!cond(w)) begin
            @(negedge i_clk_sys);
            n++;
            if (n > 600) begin
                check("wait", w, 32'hffff_ffff);
                tally_and_finish();
            end
        end
    endtask
    // data is only valid for the one sampling edge, so a wrong delay is caught
    task automatic do_write(input logic [31:0] v);
        @(posedge i_clk_sys);
        wr_req <= 1'b1;
        @(negedge i_clk_sys);
        wait_for(1);
        @(posedge i_clk_sys);
        wr_req <= 1'b0;
        // ready follows the activate by the row-to-column wait plus two cycles;
        // data is launched on the edge before the one that must sample it
        repeat (`LPC_T_RCD + WRD) @(posedge i_clk_sys);
        wr_data <= v;
        @(negedge i_clk_sys);
        check("rdy", rdy, 32'(WRD == 1));
        @(posedge i_clk_sys);
        wr_data <= ~v;
        @(negedge i_clk_sys);
        check("dq_valid", dq_valid, 32'h1);
        check("dq", dq, v);
        wait_for(3);
        check("mem_wr", last_wr, v);
    endtask
    initial begin
        repeat (5) @(negedge i_clk_sys);
        check("cke_rst", cke, 32'h0);
        check("cs_rst", cs_n, 32'h1);
        @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (2) @(negedge i_clk_sys);
        check("cfg_err", cfg_err, 32'h0);
        check("x_err", x_err, 32'h1);
        check("x_idle", 32'({x_cs_n, x_cmd, x_done, x_busy, x_dqv, x_rdy}), 32'h104);
        check("cs_w", $bits(dut_u.o_cs_n), 32'h1);
        check("ck_w", $bits(dut_u.o_ck_p), 32'h1);
        check("cke_w", $bits(dut_u.o_cke), 32'h1);
        check("dq_w", $bits(dut_u.o_dq), 32'h20);
        wait_for(0);
        check("mr1", mr1, 32'h3);
        check("wl", wl_seen, 32'h1);
        check("x_cke", x_cke, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            @(posedge i_clk_sys);
            ext_req <= seed[0];
            d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : seed;
            do_write(d);
        end
        repeat (300) @(negedge i_clk_sys);
        wait_for(3);
        check("ref_any", 32'(ref_cnt != 16'h0), 32'h1);
        check("ref_burst", 32'(ref_cnt[0]), 32'h0);
        @(posedge i_clk_sys);
        i_rstn <= 1'b0;
        @(negedge i_clk_sys);
        check("cke_rst2", cke, 32'h0);
        @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(negedge i_clk_sys);
        wait_for(0);
        do_write(32'ha5a5_5a5a);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
